// ==== common/pcmc_pkg.sv ====
// Shared constants and types of the power and clock mode controller
package pcmc_pkg;
  // Register addresses
  localparam logic [7:0] ADDR_CPU_CLOCK_CONTROL = 8'ha3;
  localparam logic [7:0] ADDR_POWER_DOWN_CONTROL = 8'ha4;
  localparam logic [7:0] ADDR_LOW_FREQ_CLOCK_CONTROL = 8'had;
  // Values after reset
  localparam logic [7:0] RST_CPU_CLOCK_CONTROL = 8'h00;
  localparam logic [7:0] RST_POWER_DOWN_CONTROL = 8'h00;
  localparam logic [7:0] RST_LOW_FREQ_CLOCK_CONTROL = 8'h07;
  // Field positions in cpu_clock_control
  localparam int CC_KEEP_XTAL_BIT = 7;
  localparam int CC_BYPASS_BIT = 6;
  localparam int CC_START_LSB = 4;
  localparam int CC_XTAL_BIT = 3;
  localparam int CC_DIV_LSB = 0;
  // Field positions in low_freq_clock_control
  localparam int LF_PHASE_BIT = 7;
  localparam int LF_READY_BIT = 6;
  localparam int LF_SEL_LSB = 0;
  // Field positions in power_down_control
  localparam int PD_PIN_BIT = 7;
  localparam int PD_TICK_BIT = 6;
  localparam int PD_COMP_BIT = 5;
  localparam int PD_MODE_LSB = 0;
  // Fast oscillator start codes
  localparam logic [1:0] START_BOTH = 2'h0;
  localparam logic [1:0] START_RC_ONLY = 2'h1;
  localparam logic [1:0] START_XTAL_ONLY = 2'h2;
  localparam logic [1:0] START_RESERVED = 2'h3;
  // Power down mode codes
  localparam logic [2:0] MODE_NONE = 3'h0;
  localparam logic [2:0] MODE_DEEP_SLEEP = 3'h1;
  localparam logic [2:0] MODE_MEMRET_OFF = 3'h2;
  localparam logic [2:0] MODE_MEMRET_ON = 3'h3;
  localparam logic [2:0] MODE_REGRET = 3'h4;
  localparam logic [2:0] MODE_RSVD_A = 3'h5;
  localparam logic [2:0] MODE_RSVD_B = 3'h6;
  localparam logic [2:0] MODE_STANDBY = 3'h7;
  // Low frequency clock sources
  localparam logic [2:0] LF_SLOW_XTAL = 3'h0;
  localparam logic [2:0] LF_SLOW_RC = 3'h1;
  localparam logic [2:0] LF_SYNTH = 3'h2;
  localparam logic [2:0] LF_PIN_ANALOG = 3'h3;
  localparam logic [2:0] LF_PIN_DIGITAL = 3'h4;
  localparam logic [2:0] LF_NONE = 3'h7;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_ACTIVE = 3'b001,
    ST_SLEEP  = 3'b010,
    ST_WAKE   = 3'b100
  } pcmc_state_t;
endpackage

// ==== verilog/pcmc_sync3.sv ====
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module pcmc_sync3 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             nrst,
  // Asynchronous input and filtered output
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_sync_out;

  if (WIDTH < 1) begin : g_bad_width
    $error("pcmc_sync3 needs WIDTH of at least one");
  end

  // Output follows only where the second and third stages agree
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      next_sync_out[i] = (stage2[i] == stage3[i]) ? stage3[i] : sync_out[i];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      stage1   <= '0;
      stage2   <= '0;
      stage3   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      stage2   <= stage1;
      stage3   <= stage2;
      sync_out <= next_sync_out;
    end
  end
endmodule

// ==== verilog/pcmc_ctrl.sv ====
// Power and clock mode controller with three special registers
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/100ps
module pcmc_ctrl (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Oscillator and clock status from outside the domain
  input  wire logic       fast_crystal_ready,
  input  wire logic       low_freq_clock,
  input  wire logic       low_freq_ready,
  // Wakeup sources from outside the domain
  input  wire logic       wake_pin,
  input  wire logic       wake_tick,
  input  wire logic       wake_comp,
  // Fast oscillator control
  output logic            fast_rc_osc_en,
  output logic            fast_crystal_osc_en,
  output logic            clk_from_crystal,
  output logic            clk_from_pin,
  output logic      [2:0] clk_div_sel,
  // Low frequency clock control
  output logic            slow_crystal_osc_en,
  output logic            slow_rc_osc_en,
  output logic            lf_synth_en,
  output logic      [2:0] lf_source_sel,
  // System control
  output logic            processor_clock_run,
  output logic      [2:0] power_mode,
  output logic            system_reset_req,
  output logic            crystal_ready_irq
);
  logic [4:0] async_bus;
  logic [4:0] sync_bus;
  logic       xtal_ready_s;
  logic       lf_phase_s;
  logic       lf_ready_s;
  logic       pin_s;
  logic       tick_s;
  logic       comp_s;

  assign async_bus = {fast_crystal_ready, low_freq_clock, low_freq_ready, wake_pin, wake_tick};

  pcmc_sync3 #(.WIDTH(5)) u_sync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .async_in (async_bus),
    .sync_out (sync_bus)
  );

  pcmc_sync3 #(.WIDTH(1)) u_sync_comp (
    .core_clk (core_clk),
    .nrst     (nrst),
    .async_in (wake_comp),
    .sync_out (comp_s)
  );

  assign {xtal_ready_s, lf_phase_s, lf_ready_s, pin_s, tick_s} = sync_bus;

  // Mode classes used in several places
  function automatic logic mode_valid(input logic [2:0] code);
    return (code != pcmc_pkg::MODE_NONE) && (code != pcmc_pkg::MODE_RSVD_A) && (code != pcmc_pkg::MODE_RSVD_B);
  endfunction

  function automatic logic mode_xtal_off(input logic [2:0] code);
    return (code == pcmc_pkg::MODE_DEEP_SLEEP) || (code == pcmc_pkg::MODE_MEMRET_OFF)
        || (code == pcmc_pkg::MODE_MEMRET_ON);
  endfunction

  function automatic logic mode_timers(input logic [2:0] code);
    return (code == pcmc_pkg::MODE_MEMRET_ON) || (code == pcmc_pkg::MODE_REGRET)
        || (code == pcmc_pkg::MODE_STANDBY);
  endfunction

  // Control state
  localparam pcmc_pkg::pcmc_state_t ST_ACTIVE = pcmc_pkg::ST_ACTIVE;
  localparam pcmc_pkg::pcmc_state_t ST_SLEEP  = pcmc_pkg::ST_SLEEP;
  localparam pcmc_pkg::pcmc_state_t ST_WAKE   = pcmc_pkg::ST_WAKE;
  pcmc_pkg::pcmc_state_t state;
  pcmc_pkg::pcmc_state_t next_state;
  logic       keep_xtal;
  logic       next_keep_xtal;
  logic       bypass;
  logic       next_bypass;
  logic [1:0] osc_start;
  logic [1:0] next_osc_start;
  logic       xtal_irq_en;
  logic       next_xtal_irq_en;
  logic [2:0] div_sel;
  logic [2:0] next_div_sel;
  logic [2:0] lf_sel;
  logic [2:0] next_lf_sel;
  logic [2:0] cause;
  logic [2:0] next_cause;
  logic [2:0] prev_mode;
  logic [2:0] next_prev_mode;
  logic [2:0] cur_mode;
  logic [2:0] next_cur_mode;
  logic       xtal_was_active;
  logic [7:0] next_reg_rdata;
  logic       next_system_reset_req;
  logic       next_crystal_ready_irq;

  logic       wr_cc;
  logic       wr_pd;
  logic       wr_lf;
  logic       rd_pd;
  logic       xtal_active;
  logic       xtal_rise;
  logic       wake_ev;
  logic       sleeping;

  assign wr_cc    = reg_wr && (reg_addr == pcmc_pkg::ADDR_CPU_CLOCK_CONTROL);
  assign wr_pd    = reg_wr && (reg_addr == pcmc_pkg::ADDR_POWER_DOWN_CONTROL);
  assign wr_lf    = reg_wr && (reg_addr == pcmc_pkg::ADDR_LOW_FREQ_CLOCK_CONTROL);
  assign rd_pd    = reg_rd && (reg_addr == pcmc_pkg::ADDR_POWER_DOWN_CONTROL);
  assign sleeping = (state == ST_SLEEP);
  // Crystal sources the clock once started and ready; RC covers the gap unless the start code is crystal-only
  assign xtal_active = (osc_start != pcmc_pkg::START_RC_ONLY) && fast_crystal_osc_en && xtal_ready_s;
  assign xtal_rise   = xtal_active && !xtal_was_active;
  assign wake_ev = pin_s || (mode_timers(cur_mode) && (tick_s || comp_s))
                || ((cur_mode == pcmc_pkg::MODE_STANDBY) && xtal_irq_en && xtal_rise);

  always_comb begin
    next_state            = state;
    next_keep_xtal        = keep_xtal;
    next_bypass           = bypass;
    next_osc_start        = osc_start;
    next_xtal_irq_en      = xtal_irq_en;
    next_div_sel          = div_sel;
    next_lf_sel           = lf_sel;
    next_cause            = cause;
    next_prev_mode        = prev_mode;
    next_cur_mode         = cur_mode;
    next_system_reset_req = 1'b0;
    next_crystal_ready_irq = xtal_irq_en && xtal_rise;
    // Whole-value writes except a reserved start code; bit 3 written means interrupt enable, read means source
    if (wr_cc) begin
      next_keep_xtal   = reg_wdata[pcmc_pkg::CC_KEEP_XTAL_BIT];
      next_bypass      = reg_wdata[pcmc_pkg::CC_BYPASS_BIT];
      next_xtal_irq_en = reg_wdata[pcmc_pkg::CC_XTAL_BIT];
      next_div_sel     = reg_wdata[pcmc_pkg::CC_DIV_LSB +: 3];
      if (reg_wdata[pcmc_pkg::CC_START_LSB +: 2] != pcmc_pkg::START_RESERVED) begin
        next_osc_start = reg_wdata[pcmc_pkg::CC_START_LSB +: 2];
      end
    end
    if (wr_lf) begin
      next_lf_sel = reg_wdata[pcmc_pkg::LF_SEL_LSB +: 3];
    end
    if (rd_pd) begin
      next_cause = 3'h0;
    end
    unique case (state)
      ST_ACTIVE: begin
        if (wr_pd && mode_valid(reg_wdata[pcmc_pkg::PD_MODE_LSB +: 3])) begin
          next_cur_mode = reg_wdata[pcmc_pkg::PD_MODE_LSB +: 3];
          next_cause    = 3'h0;
          next_state    = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake_ev) begin
          // Set wins over a read clear in the same cycle
          next_cause[2] = cause[2] || pin_s;
          next_cause[1] = cause[1] || (mode_timers(cur_mode) && tick_s);
          next_cause[0] = cause[0] || (mode_timers(cur_mode) && comp_s);
          next_prev_mode = cur_mode;
          next_state     = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if ((lf_sel == pcmc_pkg::LF_NONE) || lf_ready_s) begin
          next_system_reset_req = mode_xtal_off(cur_mode);
          next_cur_mode         = pcmc_pkg::MODE_NONE;
          next_state            = ST_ACTIVE;
        end
      end
    endcase
    next_reg_rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        pcmc_pkg::ADDR_CPU_CLOCK_CONTROL: begin
          next_reg_rdata = {keep_xtal, bypass, osc_start, xtal_active, div_sel};
        end
        pcmc_pkg::ADDR_POWER_DOWN_CONTROL: begin
          next_reg_rdata = {cause, 2'h0, prev_mode};
        end
        pcmc_pkg::ADDR_LOW_FREQ_CLOCK_CONTROL: begin
          next_reg_rdata = {lf_phase_s, lf_ready_s, 3'h0, lf_sel};
        end
        default: begin
          next_reg_rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state             <= ST_ACTIVE;
      keep_xtal         <= pcmc_pkg::RST_CPU_CLOCK_CONTROL[pcmc_pkg::CC_KEEP_XTAL_BIT];
      bypass            <= pcmc_pkg::RST_CPU_CLOCK_CONTROL[pcmc_pkg::CC_BYPASS_BIT];
      osc_start         <= pcmc_pkg::RST_CPU_CLOCK_CONTROL[pcmc_pkg::CC_START_LSB +: 2];
      xtal_irq_en       <= pcmc_pkg::RST_CPU_CLOCK_CONTROL[pcmc_pkg::CC_XTAL_BIT];
      div_sel           <= pcmc_pkg::RST_CPU_CLOCK_CONTROL[pcmc_pkg::CC_DIV_LSB +: 3];
      lf_sel            <= pcmc_pkg::RST_LOW_FREQ_CLOCK_CONTROL[pcmc_pkg::LF_SEL_LSB +: 3];
      cause             <= pcmc_pkg::RST_POWER_DOWN_CONTROL[pcmc_pkg::PD_COMP_BIT +: 3];
      prev_mode         <= pcmc_pkg::RST_POWER_DOWN_CONTROL[pcmc_pkg::PD_MODE_LSB +: 3];
      cur_mode          <= pcmc_pkg::MODE_NONE;
      xtal_was_active   <= 1'b0;
      reg_rdata         <= 8'h00;
      system_reset_req  <= 1'b0;
      crystal_ready_irq <= 1'b0;
    end else begin
      state             <= next_state;
      keep_xtal         <= next_keep_xtal;
      bypass            <= next_bypass;
      osc_start         <= next_osc_start;
      xtal_irq_en       <= next_xtal_irq_en;
      div_sel           <= next_div_sel;
      lf_sel            <= next_lf_sel;
      cause             <= next_cause;
      prev_mode         <= next_prev_mode;
      cur_mode          <= next_cur_mode;
      xtal_was_active   <= xtal_active;
      reg_rdata         <= next_reg_rdata;
      system_reset_req  <= next_system_reset_req;
      crystal_ready_irq <= next_crystal_ready_irq;
    end
  end

  // Clock and oscillator outputs
  logic       next_fast_rc_osc_en;
  logic       next_fast_crystal_osc_en;
  logic       next_slow_crystal_osc_en;
  logic       next_slow_rc_osc_en;
  logic       next_lf_synth_en;
  logic       lf_off;

  always_comb begin
    lf_off = sleeping && (cur_mode == pcmc_pkg::MODE_DEEP_SLEEP || cur_mode == pcmc_pkg::MODE_MEMRET_OFF);
    next_fast_rc_osc_en = (osc_start != pcmc_pkg::START_XTAL_ONLY) && !sleeping;
    next_fast_crystal_osc_en = (osc_start != pcmc_pkg::START_RC_ONLY)
        && (!sleeping || (cur_mode == pcmc_pkg::MODE_STANDBY)
            || ((cur_mode == pcmc_pkg::MODE_REGRET) && keep_xtal));
    next_slow_crystal_osc_en = (lf_sel == pcmc_pkg::LF_SLOW_XTAL) && !lf_off;
    next_slow_rc_osc_en      = (lf_sel == pcmc_pkg::LF_SLOW_RC) && !lf_off;
    next_lf_synth_en = (lf_sel == pcmc_pkg::LF_SYNTH) && xtal_active
        && !(sleeping && mode_xtal_off(cur_mode));
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      fast_rc_osc_en      <= 1'b0;
      fast_crystal_osc_en <= 1'b0;
      clk_from_crystal    <= 1'b0;
      clk_from_pin        <= 1'b0;
      clk_div_sel         <= 3'h0;
      slow_crystal_osc_en <= 1'b0;
      slow_rc_osc_en      <= 1'b0;
      lf_synth_en         <= 1'b0;
      lf_source_sel       <= pcmc_pkg::LF_NONE;
      processor_clock_run <= 1'b0;
      power_mode          <= pcmc_pkg::MODE_NONE;
    end else begin
      fast_rc_osc_en      <= next_fast_rc_osc_en;
      fast_crystal_osc_en <= next_fast_crystal_osc_en;
      clk_from_crystal    <= xtal_active;
      clk_from_pin        <= bypass;
      clk_div_sel         <= div_sel;
      slow_crystal_osc_en <= next_slow_crystal_osc_en;
      slow_rc_osc_en      <= next_slow_rc_osc_en;
      lf_synth_en         <= next_lf_synth_en;
      lf_source_sel       <= lf_sel;
      processor_clock_run <= (state == ST_ACTIVE);
      power_mode          <= cur_mode;
    end
  end

  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  a_read_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read answer");
  a_mode_enter: assert property ((state == ST_ACTIVE) && wr_pd && mode_valid(reg_wdata[2:0])
      |=> (state == ST_SLEEP) && (cur_mode == $past(reg_wdata[2:0])) && (cause == 3'h0))
    else $error("power down write did not enter its mode");
  a_rsvd_mode_ignored: assert property ((state == ST_ACTIVE) && wr_pd && !mode_valid(reg_wdata[2:0])
      |=> state == ST_ACTIVE)
    else $error("reserved power code changed power state");
  a_rsvd_start_kept: assert property (wr_cc && (reg_wdata[5:4] == pcmc_pkg::START_RESERVED)
      |=> $stable(osc_start))
    else $error("reserved start code changed oscillator start");
  a_clock_stopped: assert property ((state != ST_ACTIVE) |=> !processor_clock_run)
    else $error("processor clock runs outside active state");
  a_lf_wait: assert property ((state == ST_WAKE) && (lf_sel != pcmc_pkg::LF_NONE) && !lf_ready_s
      |=> state == ST_WAKE)
    else $error("processor started before low frequency clock ready");
  a_flag_read_clear: assert property (rd_pd && !(sleeping && wake_ev) |=> cause == 3'h0)
    else $error("wake flags survived a read");
  a_reset_on_wake: assert property ((state == ST_WAKE) && (next_state == ST_ACTIVE)
      |=> system_reset_req == mode_xtal_off($past(cur_mode)))
    else $error("wake reset request wrong for previous mode");
  a_regret_resume: assert property ((state == ST_WAKE) && (cur_mode == pcmc_pkg::MODE_REGRET)
      |=> !system_reset_req)
    else $error("register retention wake raised a reset");
  a_prev_mode_kept: assert property ((state == ST_SLEEP) && wake_ev
      |=> ##1 (state == ST_WAKE || state == ST_ACTIVE) && (prev_mode == $past(cur_mode, 2)))
    else $error("previous mode not recorded on wake");
  a_xtal_keep_regret: assert property (sleeping && (cur_mode == pcmc_pkg::MODE_REGRET) && keep_xtal
      && (osc_start != pcmc_pkg::START_RC_ONLY) |=> fast_crystal_osc_en)
    else $error("crystal stopped in register retention despite keep");
  a_bypass_follow: assert property (wr_cc |=> ##1 clk_from_pin == $past(reg_wdata[6], 2))
    else $error("bypass select does not follow write");
  a_synth_stops: assert property (sleeping && mode_xtal_off(cur_mode) |=> !lf_synth_en)
    else $error("synthesised clock runs in deep sleep");

  c_standby_wake: cover property ((state == ST_SLEEP) && (cur_mode == pcmc_pkg::MODE_STANDBY) ##1 state == ST_WAKE);
  c_reset_wake: cover property (system_reset_req);
  c_xtal_switch: cover property (!clk_from_crystal ##1 clk_from_crystal);
  c_lf_wait: cover property ((state == ST_WAKE) [*3] ##1 state == ST_ACTIVE);
endmodule

// ==== verification/pcmc_osc_model.sv ====
// Behavioural model of the fast crystal and the low frequency clock sources
`timescale 1ns/100ps
module pcmc_osc_model #(
  parameter int XTAL_DLY = 16,
  parameter int LF_DLY   = 8
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // Oscillator controls from the block
  input  wire logic       fast_crystal_osc_en,
  input  wire logic       slow_crystal_osc_en,
  input  wire logic       slow_rc_osc_en,
  input  wire logic       lf_synth_en,
  input  wire logic [2:0] lf_source_sel,
  // Keeps the low frequency clock from becoming operative
  input  wire logic       lf_stall,
  // Status back to the block
  output logic            fast_crystal_ready,
  output logic            low_freq_clock,
  output logic            low_freq_ready
);
  int         xtal_cnt = 0;
  int         lf_cnt   = 0;
  logic [2:0] ph_cnt   = 3'h0;
  logic       src_on;
  assign fast_crystal_ready = (xtal_cnt == XTAL_DLY);
  assign low_freq_ready     = (lf_cnt == LF_DLY) && !lf_stall;
  assign low_freq_clock     = ph_cnt[2];
  // Pin sources are taken as always present
  always_comb begin
    case (lf_source_sel)
      3'h0:    src_on = slow_crystal_osc_en;
      3'h1:    src_on = slow_rc_osc_en;
      3'h2:    src_on = lf_synth_en && fast_crystal_ready;
      3'h3,
      3'h4:    src_on = 1'b1;
      default: src_on = 1'b0;
    endcase
  end
  always @(posedge core_clk) begin
    xtal_cnt <= (!nrst || !fast_crystal_osc_en) ? 0 : ((xtal_cnt < XTAL_DLY) ? xtal_cnt + 1 : xtal_cnt);
    lf_cnt   <= (!nrst || !src_on) ? 0 : ((lf_cnt < LF_DLY) ? lf_cnt + 1 : lf_cnt);
    ph_cnt   <= (lf_cnt == LF_DLY) ? ph_cnt + 3'h1 : 3'h0;
  end
endmodule

// ==== verification/tb.sv ====
// Self-checking bench for the power and clock mode controller
`timescale 1ns/100ps
module tb;
  logic       core_clk = 1'b0;
  logic       nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       wake_pin = 1'b0, wake_tick = 1'b0, wake_comp = 1'b0, lf_stall = 1'b0;
  logic [7:0] reg_rdata;
  logic       fast_crystal_ready, low_freq_clock, low_freq_ready;
  logic       fast_rc_osc_en, fast_crystal_osc_en, clk_from_crystal, clk_from_pin;
  logic       slow_crystal_osc_en, slow_rc_osc_en, lf_synth_en;
  logic [2:0] clk_div_sel, lf_source_sel, power_mode;
  logic       processor_clock_run, system_reset_req, crystal_ready_irq;
  int         n_fail = 0;
  int         checked = 0;
  int         n_rstreq = 0;
  int         n_irq = 0;
  int         cycles = 0;
  int         base;
  logic [7:0] rd, ph_or, ph_and;
  logic       keep = 1'b0;
  logic [2:0] lf_codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};

  pcmc_ctrl DUT (.core_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .fast_crystal_ready, .low_freq_clock, .low_freq_ready, .wake_pin, .wake_tick, .wake_comp,
    .fast_rc_osc_en, .fast_crystal_osc_en, .clk_from_crystal, .clk_from_pin, .clk_div_sel,
    .slow_crystal_osc_en, .slow_rc_osc_en, .lf_synth_en, .lf_source_sel,
    .processor_clock_run, .power_mode, .system_reset_req, .crystal_ready_irq);
  pcmc_osc_model osc (.core_clk, .nrst, .fast_crystal_osc_en, .slow_crystal_osc_en, .slow_rc_osc_en,
    .lf_synth_en, .lf_source_sel, .lf_stall, .fast_crystal_ready, .low_freq_clock, .low_freq_ready);

  initial begin
    forever #2 core_clk = ~core_clk;
  end

  task automatic tally_and_finish;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Pulse counters and hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (system_reset_req === 1'b1) n_rstreq <= n_rstreq + 1;
    if (crystal_ready_irq === 1'b1) n_irq <= n_irq + 1;
    if (cycles == 20000) begin
      n_fail = n_fail + 1;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask

  task automatic pulse(input logic [2:0] w);
    @(posedge core_clk);
    {wake_pin, wake_tick, wake_comp} <= w;
    repeat (8) @(posedge core_clk);
    {wake_pin, wake_tick, wake_comp} <= 3'h0;
  endtask

  task automatic wait_run;
    for (int i = 0; i < 100 && processor_clock_run !== 1'b1; i++) @(posedge core_clk);
    #1 chk(8'(processor_clock_run), 8'h01);
  endtask

  task automatic sleep(input logic [2:0] mode, input logic [2:0] w, input int rst_exp);
    int r0;
    r0 = n_rstreq;
    wr(pcmc_pkg::ADDR_POWER_DOWN_CONTROL, {5'h00, mode});
    repeat (3) @(posedge core_clk);
    #1 chk(8'(power_mode), 8'(mode));
    chk(8'(processor_clock_run), 8'h00);
    chk(8'(fast_crystal_osc_en), 8'((mode == 3'h7) || (mode == 3'h4 && keep)));
    if (mode < 3'h3) begin
      chk(8'(lf_synth_en), 8'h00);
      pulse(3'h2);
      repeat (20) @(posedge core_clk);
      #1 chk(8'(processor_clock_run), 8'h00);
      wr(pcmc_pkg::ADDR_LOW_FREQ_CLOCK_CONTROL, 8'h07);
    end
    pulse(w);
    wait_run();
    rdr(pcmc_pkg::ADDR_POWER_DOWN_CONTROL);
    chk(rd, {w, 2'b00, mode});
    rdr(pcmc_pkg::ADDR_POWER_DOWN_CONTROL);
    chk(rd, {5'h00, mode});
    chk(8'(n_rstreq - r0), 8'(rst_exp));
    $display("test sleep mode %0d done", mode);
  endtask

  initial begin
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    rdr(pcmc_pkg::ADDR_CPU_CLOCK_CONTROL);
    chk(rd, pcmc_pkg::RST_CPU_CLOCK_CONTROL);
    rdr(pcmc_pkg::ADDR_POWER_DOWN_CONTROL);
    chk(rd, pcmc_pkg::RST_POWER_DOWN_CONTROL);
    rdr(pcmc_pkg::ADDR_LOW_FREQ_CLOCK_CONTROL);
    chk(rd & 8'h7f, pcmc_pkg::RST_LOW_FREQ_CLOCK_CONTROL);
    wr(8'ha5, 8'hff);
    rdr(8'ha5);
    chk(rd, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      wr(pcmc_pkg::ADDR_CPU_CLOCK_CONTROL, 8'(i));
      rdr(pcmc_pkg::ADDR_CPU_CLOCK_CONTROL);
      chk(rd & 8'hf7, 8'(i));
      chk(8'(clk_div_sel), 8'(i));
    end
    $display("test divider done");
    // Code 3 is reserved and must leave the crystal-only setting in force
    for (int i = 0; i < 4; i++) begin
      wr(pcmc_pkg::ADDR_CPU_CLOCK_CONTROL, 8'(i << 4));
      repeat (2) @(posedge core_clk);
      #1 chk(8'(fast_rc_osc_en), 8'(i < 2));
      chk(8'(fast_crystal_osc_en), 8'(i != 1));
    end
    wr(pcmc_pkg::ADDR_CPU_CLOCK_CONTROL, 8'h40);
    rdr(pcmc_pkg::ADDR_CPU_CLOCK_CONTROL);
    chk(rd & 8'hf7, 8'h40);
    chk(8'(clk_from_pin), 8'h01);
    $display("test oscillator start done");
    wr(pcmc_pkg::ADDR_CPU_CLOCK_CONTROL, 8'h18);
    repeat (10) @(posedge core_clk);
    base = n_irq;
    wr(pcmc_pkg::ADDR_CPU_CLOCK_CONTROL, 8'h08);
    repeat (40) @(posedge core_clk);
    #1 chk(8'(n_irq - base), 8'h01);
    chk(8'(clk_from_crystal), 8'h01);
    rdr(pcmc_pkg::ADDR_CPU_CLOCK_CONTROL);
    chk(rd, 8'h08);
    wr(pcmc_pkg::ADDR_CPU_CLOCK_CONTROL, 8'h10);
    repeat (10) @(posedge core_clk);
    rdr(pcmc_pkg::ADDR_CPU_CLOCK_CONTROL);
    chk(rd, 8'h10);
    chk(8'(clk_from_crystal), 8'h00);
    base = n_irq;
    wr(pcmc_pkg::ADDR_CPU_CLOCK_CONTROL, 8'h00);
    repeat (40) @(posedge core_clk);
    #1 chk(8'(n_irq - base), 8'h00);
    $display("test crystal switch done");
    for (int i = 0; i < 6; i++) begin
      wr(pcmc_pkg::ADDR_LOW_FREQ_CLOCK_CONTROL, {5'h00, lf_codes[i]});
      repeat (20) @(posedge core_clk);
      rdr(pcmc_pkg::ADDR_LOW_FREQ_CLOCK_CONTROL);
      chk(rd & 8'h47, {1'b0, lf_codes[i] != 3'h7, 3'h0, lf_codes[i]});
      chk(8'(lf_source_sel), 8'(lf_codes[i]));
      chk({slow_crystal_osc_en, slow_rc_osc_en}, {lf_codes[i] == 3'h0, lf_codes[i] == 3'h1});
    end
    // Phase bit moves while the slow RC source is running
    wr(pcmc_pkg::ADDR_LOW_FREQ_CLOCK_CONTROL, 8'h01);
    repeat (20) @(posedge core_clk);
    ph_or = 8'h00;
    ph_and = 8'hff;
    for (int i = 0; i < 8; i++) begin
      rdr(pcmc_pkg::ADDR_LOW_FREQ_CLOCK_CONTROL);
      ph_or = ph_or | rd;
      ph_and = ph_and & rd;
    end
    chk({ph_or[7], ph_and[7]}, 8'h02);
    wr(pcmc_pkg::ADDR_LOW_FREQ_CLOCK_CONTROL, 8'h07);
    $display("test low frequency source done");
    for (int i = 0; i < 3; i++) begin
      wr(pcmc_pkg::ADDR_POWER_DOWN_CONTROL, 8'(i == 0 ? 0 : i + 4));
      repeat (3) @(posedge core_clk);
      #1 chk({power_mode, processor_clock_run}, 8'h01);
    end
    $display("test reserved modes done");
    keep = 1'b1;
    wr(pcmc_pkg::ADDR_CPU_CLOCK_CONTROL, 8'h80);
    sleep(3'h4, 3'h4, 0);
    keep = 1'b0;
    wr(pcmc_pkg::ADDR_CPU_CLOCK_CONTROL, 8'h00);
    sleep(3'h4, 3'h2, 0);
    sleep(3'h3, 3'h1, 1);
    wr(pcmc_pkg::ADDR_LOW_FREQ_CLOCK_CONTROL, 8'h02);
    sleep(3'h2, 3'h4, 1);
    wr(pcmc_pkg::ADDR_LOW_FREQ_CLOCK_CONTROL, 8'h02);
    sleep(3'h1, 3'h4, 1);
    sleep(3'h7, 3'h4, 0);
    // Wake must wait for the selected low frequency clock
    wr(pcmc_pkg::ADDR_LOW_FREQ_CLOCK_CONTROL, 8'h01);
    lf_stall <= 1'b1;
    wr(pcmc_pkg::ADDR_POWER_DOWN_CONTROL, 8'h04);
    pulse(3'h4);
    repeat (40) @(posedge core_clk);
    #1 chk(8'(processor_clock_run), 8'h00);
    @(posedge core_clk);
    lf_stall <= 1'b0;
    wait_run();
    rdr(pcmc_pkg::ADDR_POWER_DOWN_CONTROL);
    chk(rd, 8'h84);
    $display("test wake hold-off done");
    // Entering a power down mode drops flags left from the last wake
    wr(pcmc_pkg::ADDR_POWER_DOWN_CONTROL, 8'h07);
    pulse(3'h2);
    wait_run();
    repeat (8) @(posedge core_clk);
    wr(pcmc_pkg::ADDR_POWER_DOWN_CONTROL, 8'h07);
    pulse(3'h4);
    wait_run();
    rdr(pcmc_pkg::ADDR_POWER_DOWN_CONTROL);
    chk(rd, 8'h87);
    $display("test flag clear on entry done");
    // A crystal becoming ready wakes standby when its interrupt is enabled
    wr(pcmc_pkg::ADDR_CPU_CLOCK_CONTROL, 8'h18);
    wr(pcmc_pkg::ADDR_POWER_DOWN_CONTROL, 8'h07);
    repeat (8) @(posedge core_clk);
    base = n_irq;
    wr(pcmc_pkg::ADDR_CPU_CLOCK_CONTROL, 8'h08);
    wait_run();
    repeat (2) @(posedge core_clk);
    #1 chk(8'(n_irq - base), 8'h01);
    rdr(pcmc_pkg::ADDR_POWER_DOWN_CONTROL);
    chk(rd, 8'h07);
    $display("test crystal wake done");
    tally_and_finish();
  end
endmodule
